// >>> pkg/clock_control_consts.svh
// Offsets, field positions, reset values and timing counts of the clock control block
`ifndef CLOCK_CONTROL_CONSTS_SVH
`define CLOCK_CONTROL_CONSTS_SVH

`define CLK_CTRL_ADDR 8'hd8
`define CLK_STATUS_ADDR 8'hf8

`define CLK_CTRL_RESET 8'h23
`define CLK_STATUS_RESET 8'h00

`define SLOW_HALT_BIT 5
`define PERIPH_GATE_BIT 4
`define FAST_HALT_BIT 3
`define SOURCE_SEL_BIT 2
`define DIVIDER_LSB 0
`define DIVIDER_MSB 1

`define STAT_FAST_RUN_BIT 0
`define STAT_SLOW_RUN_BIT 1
`define STAT_PERIPH_RUN_BIT 2
`define STAT_SOURCE_BIT 3
`define STAT_REFUSED_BIT 4

`define DIV_BY_16 2'h0
`define DIV_BY_4 2'h1
`define DIV_BY_2 2'h2
`define DIV_BY_1 2'h3

`define DIVIDER_SETTLE_CYCLES 16
`define DIV_COUNT_W 4

`endif

// >>> pkg/clock_control_pkg.sv
// Types shared by the clock control block
package clock_control_pkg;

	typedef struct packed {
		logic slow_osc_halt_in_powerdown;
		logic peripheral_clock_gate_in_idle;
		logic fast_osc_halt;
		logic clock_source_select;
		logic [1:0] system_clock_divider;
	} clock_ctrl_t;

	typedef struct packed {
		logic change_refused;
		logic source_is_fast;
		logic periph_running;
		logic slow_osc_running;
		logic fast_osc_running;
	} clock_status_t;

	typedef struct packed {
		logic idle_mode;
		logic power_down_mode;
	} power_mode_t;

endpackage

// >>> design/system_clock_select_prescale.sv
// System clock source select, prescaler and low-power clock gating
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "clock_control_consts.svh"

// Notes on behaviour
// - Slow halt bit set stops slow oscillator while in power-down mode.
// - Peripheral gate bit set stops serial and timer clocks in idle mode.
// - Fast halt bit set stops fast oscillator in slow and idle modes.
// - Fast halt bit may change only while running from the slow clock.
// - Source select: 0 picks slow clock, 1 picks fast clock.
// - Source select may change only while fast halt bit is clear.
// - Divider field 00,01,10,11 divides source by 16, 4, 2, 1.
// - New divider setting reaches the system clock within 16 cycles.
module system_clock_select_prescale #(
	parameter int DIV_COUNT_W = `DIV_COUNT_W
) (
	input wire logic clk_in,                // 40 MHz block clock
	input wire logic sys_rst_in,            // Synchronous reset, active high
	input wire logic [7:0] reg_addr_in,     // Register address
	input wire logic [7:0] reg_wdata_in,    // Register write data
	input wire logic reg_wr_in,             // Write strobe
	input wire logic reg_rd_in,             // Read strobe
	output logic [7:0] reg_rdata_out,       // Read data, cycle after strobe
	input wire logic fast_src_tick_in,      // Fast source clock enable pulse
	input wire logic slow_src_tick_in,      // Slow source clock enable pulse
	input wire logic idle_mode_in,          // Device in idle mode
	input wire logic power_down_mode_in,    // Device in power-down mode
	output logic sys_clk_en_out,            // System clock enable pulse
	output logic periph_clk_en_out,         // Serial/timer clock enable pulse
	output logic fast_osc_run_out,          // Fast oscillator enable
	output logic slow_osc_run_out,          // Slow oscillator enable
	output logic source_is_fast_out         // Active source is fast clock
);

	clock_control_pkg::clock_ctrl_t ctrl;
	clock_control_pkg::clock_ctrl_t next_ctrl;
	clock_control_pkg::clock_status_t status;
	clock_control_pkg::power_mode_t mode;
	logic refused;
	logic next_refused;
	logic [7:0] rdata;
	logic [7:0] next_rdata;
	logic [1:0] active_div;
	logic [1:0] next_active_div;
	logic [DIV_COUNT_W-1:0] div_count;
	logic [DIV_COUNT_W-1:0] next_div_count;
	logic sys_tick;
	logic next_sys_tick;
	logic periph_tick;
	logic next_periph_tick;
	logic source_tick;
	logic fast_run;
	logic slow_run;
	logic ctrl_wr;
	logic status_rd;
	logic write_refused;

	// Terminal count of the prescaler for a divider code
	function automatic logic [DIV_COUNT_W-1:0] div_last(input logic [1:0] code);
		logic [DIV_COUNT_W-1:0] last;
		last = '0;
		case (code)
			`DIV_BY_16: last = DIV_COUNT_W'(`DIVIDER_SETTLE_CYCLES - 1);
			`DIV_BY_4: last = DIV_COUNT_W'(3);
			`DIV_BY_2: last = DIV_COUNT_W'(1);
			`DIV_BY_1: last = '0;
			default: last = '0;
		endcase
		return last;
	endfunction

	// Register image with reserved bits reading zero
	function automatic logic [7:0] ctrl_image(input clock_control_pkg::clock_ctrl_t c);
		return {2'h0, c};
	endfunction

	assign mode.idle_mode = idle_mode_in;
	assign mode.power_down_mode = power_down_mode_in;
	assign ctrl_wr = reg_wr_in && (reg_addr_in == `CLK_CTRL_ADDR);
	assign status_rd = reg_rd_in && (reg_addr_in == `CLK_STATUS_ADDR);

	// Oscillator enables from the current control bits and power mode
	always_comb begin
		fast_run = 1'b1;
		slow_run = 1'b1;
		if (ctrl.fast_osc_halt && (!ctrl.clock_source_select || mode.idle_mode)) begin
			fast_run = 1'b0;
		end
		if (ctrl.slow_osc_halt_in_powerdown && mode.power_down_mode) begin
			slow_run = 1'b0;
		end
	end

	// Selected source tick, only from a running oscillator
	always_comb begin
		if (ctrl.clock_source_select) begin
			source_tick = fast_src_tick_in && fast_run;
		end else begin
			source_tick = slow_src_tick_in && slow_run;
		end
	end

	// Control register update with change restrictions
	always_comb begin
		next_ctrl = ctrl;
		write_refused = 1'b0;
		if (ctrl_wr) begin
			next_ctrl.slow_osc_halt_in_powerdown = reg_wdata_in[`SLOW_HALT_BIT];
			next_ctrl.peripheral_clock_gate_in_idle = reg_wdata_in[`PERIPH_GATE_BIT];
			next_ctrl.system_clock_divider = reg_wdata_in[`DIVIDER_MSB:`DIVIDER_LSB];
			if (!ctrl.clock_source_select) begin
				next_ctrl.fast_osc_halt = reg_wdata_in[`FAST_HALT_BIT];
			end else if (reg_wdata_in[`FAST_HALT_BIT] != ctrl.fast_osc_halt) begin
				write_refused = 1'b1;
			end
			if (!ctrl.fast_osc_halt) begin
				next_ctrl.clock_source_select = reg_wdata_in[`SOURCE_SEL_BIT];
			end else if (reg_wdata_in[`SOURCE_SEL_BIT] != ctrl.clock_source_select) begin
				write_refused = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			ctrl <= clock_control_pkg::clock_ctrl_t'(6'(`CLK_CTRL_RESET));
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// Sticky refused flag; a new refusal wins over the read clear
	always_comb begin
		next_refused = refused;
		if (status_rd) begin
			next_refused = 1'b0;
		end
		if (write_refused) begin
			next_refused = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			refused <= 1'b0;
		end else begin
			refused <= next_refused;
		end
	end

	// Prescaler: a new divider is taken at once and the count restarts
	always_comb begin
		next_active_div = active_div;
		next_div_count = div_count;
		next_sys_tick = 1'b0;
		if (active_div != ctrl.system_clock_divider) begin
			next_active_div = ctrl.system_clock_divider;
			next_div_count = '0;
		end else if (source_tick && !mode.power_down_mode) begin
			if (div_count >= div_last(active_div)) begin
				next_div_count = '0;
				next_sys_tick = 1'b1;
			end else begin
				next_div_count = div_count + DIV_COUNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			active_div <= `DIV_BY_1;
			div_count <= '0;
			sys_tick <= 1'b0;
		end else begin
			active_div <= next_active_div;
			div_count <= next_div_count;
			sys_tick <= next_sys_tick;
		end
	end

	// Peripheral clock follows the system clock unless gated in idle
	always_comb begin
		next_periph_tick = next_sys_tick;
		if (ctrl.peripheral_clock_gate_in_idle && mode.idle_mode) begin
			next_periph_tick = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			periph_tick <= 1'b0;
		end else begin
			periph_tick <= next_periph_tick;
		end
	end

	// Status image of the block's own state
	always_comb begin
		status.change_refused = refused;
		status.source_is_fast = ctrl.clock_source_select;
		status.periph_running = !(ctrl.peripheral_clock_gate_in_idle && mode.idle_mode);
		status.slow_osc_running = slow_run;
		status.fast_osc_running = fast_run;
	end

	// Read data stands in the cycle after the strobe only
	always_comb begin
		next_rdata = 8'h00;
		if (reg_rd_in) begin
			case (reg_addr_in)
				`CLK_CTRL_ADDR: next_rdata = ctrl_image(ctrl);
				`CLK_STATUS_ADDR: next_rdata = {3'h0, status};
				default: next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata <= 8'h00;
		end else begin
			rdata <= next_rdata;
		end
	end

	assign reg_rdata_out = rdata;
	assign sys_clk_en_out = sys_tick;
	assign periph_clk_en_out = periph_tick;
	assign fast_osc_run_out = fast_run;
	assign slow_osc_run_out = slow_run;
	assign source_is_fast_out = ctrl.clock_source_select;

endmodule

// >>> verif/system_clock_select_prescale_properties.sv
// Port-level checks for the clock select and prescaler
`timescale 1ns/10ps
`include "clock_control_consts.svh"
module system_clock_select_prescale_properties (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic idle_mode_in,
	input wire logic power_down_mode_in,
	input wire logic sys_clk_en_out,
	input wire logic periph_clk_en_out,
	input wire logic fast_osc_run_out,
	input wire logic slow_osc_run_out,
	input wire logic source_is_fast_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	wire ctl_wr = reg_wr_in && reg_addr_in == `CLK_CTRL_ADDR;
	a_slow_awake: assert property (!power_down_mode_in |-> slow_osc_run_out)
		else $error("slow oscillator stopped while awake");
	a_pd_no_clk: assert property (power_down_mode_in [*2] |=> !sys_clk_en_out)
		else $error("system pulse in power-down");
	a_periph_sub: assert property (periph_clk_en_out |-> sys_clk_en_out)
		else $error("peripheral pulse without system pulse");
	a_periph_awake: assert property (sys_clk_en_out && !idle_mode_in && !$past(idle_mode_in)
		|-> periph_clk_en_out)
		else $error("peripheral pulse gated outside idle");
	a_fast_kept: assert property (source_is_fast_out && !idle_mode_in |-> fast_osc_run_out)
		else $error("active fast oscillator halted");
	// In idle a running fast source means the halt bit is clear
	a_sel_write: assert property (ctl_wr && source_is_fast_out && idle_mode_in && fast_osc_run_out
		|=> source_is_fast_out == $past(reg_wdata_in[`SOURCE_SEL_BIT]))
		else $error("source select write lost");
	a_sel_hold: assert property (!ctl_wr |=> $stable(source_is_fast_out))
		else $error("source changed without a write");
	a_rdata_drop: assert property (reg_rd_in ##1 !reg_rd_in |=> reg_rdata_out == 8'h00)
		else $error("read data held too long");
	cover property (ctl_wr && source_is_fast_out);
	cover property (idle_mode_in && sys_clk_en_out && !periph_clk_en_out);
	cover property (power_down_mode_in && !slow_osc_run_out);
endmodule
bind system_clock_select_prescale system_clock_select_prescale_properties chk (.*);

// >>> verif/system_clock_select_prescale_tb_top.sv
// Self-checking bench for the clock select and prescaler
`timescale 1ns/10ps
`include "clock_control_consts.svh"
module system_clock_select_prescale_tb_top;
	logic clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, rd_seen = 0;
	logic fast_src_tick_in = 0, slow_src_tick_in = 0, idle_mode_in = 0, power_down_mode_in = 0;
	logic [7:0] reg_addr_in = 8'h00, reg_wdata_in = 8'h00, reg_rdata_out, ctrl, d;
	logic refd = 0;
	logic sys_clk_en_out, periph_clk_en_out, fast_osc_run_out, slow_osc_run_out;
	logic source_is_fast_out;
	logic [7:0] exp_q[$];
	// Control, ticks/idle/pd, system and peripheral pulses per 64, osc run levels
	logic [31:0] tbl[10] = '{32'h20404043, 32'h21410103, 32'h22420203, 32'h23440403,
		32'h27840403, 32'h37a40003, 32'h21410103, 32'h2b440401, 32'h23500002, 32'h03500003};
	int failures = 0, cmp_count = 0, seed = 32'h5d90, ns, np;
	system_clock_select_prescale DUT (.*);
	initial forever #12.5 clk_in = ~clk_in;
	task cmp8(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] w);
		reg_wr_in <= 1;
		reg_addr_in <= a;
		reg_wdata_in <= w;
		@(posedge clk_in);
		reg_wr_in <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		reg_rd_in <= 1;
		reg_addr_in <= a;
		@(posedge clk_in);
		reg_rd_in <= 0;
	endtask
	function automatic logic [7:0] nx(input logic [7:0] o, input logic [7:0] w);
		nx = w & 8'h3f;
		if (o[2]) nx[3] = o[3];
		if (o[3]) nx[2] = o[2];
	endfunction
	task give_verdict;
		$display("Mismatches %0d of %0d comparisons", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_in) begin
		rd_seen <= reg_rd_in;
		if (rd_seen) cmp8("rdata", exp_q.pop_front(), reg_rdata_out);
	end
	initial begin
		#(25 * 5000);
		failures++;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 0;
		rd(`CLK_CTRL_ADDR, `CLK_CTRL_RESET);
		for (int i = 0; i < 10; i++) begin
			{fast_src_tick_in, slow_src_tick_in, idle_mode_in, power_down_mode_in} <= tbl[i][23:20];
			wr(`CLK_CTRL_ADDR, tbl[i][31:24]);
			rd(`CLK_CTRL_ADDR, tbl[i][31:24]);
			repeat (16) @(posedge clk_in);
			ns = 0;
			np = 0;
			repeat (64) @(posedge clk_in) begin
				ns += sys_clk_en_out;
				np += periph_clk_en_out;
			end
			cmp8("sys pulses", tbl[i][19:12], 8'(ns));
			cmp8("periph pulses", tbl[i][11:4], 8'(np));
			cmp8("osc run", {6'h0, tbl[i][1:0]}, {6'h0, fast_osc_run_out, slow_osc_run_out});
		end
		// Idle during the random writes so the checker can see select writes land
		{fast_src_tick_in, slow_src_tick_in, idle_mode_in, power_down_mode_in} <= 4'he;
		ctrl = 8'h03;
		for (int i = 0; i < 24; i++) begin
			d = 8'($random(seed));
			wr(`CLK_CTRL_ADDR, d);
			refd = refd | (ctrl[2] && d[3] != ctrl[3]) | (ctrl[3] && d[2] != ctrl[2]);
			ctrl = nx(ctrl, d);
			rd(`CLK_CTRL_ADDR, ctrl);
		end
		@(posedge clk_in);
		rd(8'h55, 8'h00);
		wr(8'hd9, 8'hff);
		rd(`CLK_CTRL_ADDR, ctrl);
		// Status in idle: fast runs only with halt clear, slow always runs
		rd(`CLK_STATUS_ADDR, {3'h0, refd, ctrl[2], ~ctrl[4], 1'b1, ~ctrl[3]});
		rd(`CLK_STATUS_ADDR, {3'h0, 1'b0, ctrl[2], ~ctrl[4], 1'b1, ~ctrl[3]});
		repeat (3) @(posedge clk_in);
		give_verdict;
	end
endmodule
